/* File: dv/clk_cfg_block_chk.sv */
/*
  concurrent checks on the clock configuration block ports.
  assumes one clock, synchronous active-high reset, bound to clk_cfg_block.
*/
`timescale 1ns/1ps
`default_nettype none
module clk_cfg_block_chk (
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_reset,
  input wire logic        i_clk_en,
  // read channel
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  // clock tree
  input wire logic        o_pll_power_down,
  input wire logic        o_pll_output_enable_n,
  input wire logic        o_sel_oscillator,
  input wire logic [5:0]  o_eff_divisor,
  input wire logic        o_sys_tick
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence ar_take;
    i_s_axi_arvalid && o_s_axi_arready && i_clk_en;
  endsequence
  sequence r_wait;
    o_s_axi_rvalid && !i_s_axi_rready;
  endsequence
  pd_reset_a: assert property ($fell(i_reset) |-> o_pll_power_down)
    else $error("power-down not high after reset");
  oen_reset_a: assert property ($fell(i_reset) |-> o_pll_output_enable_n)
    else $error("output enable not inactive after reset");
  osc_reset_a: assert property ($fell(i_reset) |-> o_sel_oscillator)
    else $error("oscillator not selected after reset");
  div_reset_a: assert property ($fell(i_reset) |-> o_eff_divisor == 6'h0f)
    else $error("divisor not 0xf after reset");
  rsv_zero_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[21:14] == 8'h00)
    else $error("reserved bits read nonzero");
  pll_gap_a: assert property (
    !o_sel_oscillator && o_sys_tick && o_eff_divisor != 6'h00 && i_clk_en |=> !o_sys_tick)
    else $error("pll tick not divided");
  read_lat_a: assert property (ar_take |=> o_s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (r_wait |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data not held");
endmodule // clk_cfg_block_chk
bind clk_cfg_block clk_cfg_block_chk chk_u (.i_core_clk, .i_reset, .i_clk_en, .i_s_axi_arvalid,
  .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata, .o_pll_power_down,
  .o_pll_output_enable_n, .o_sel_oscillator, .o_eff_divisor, .o_sys_tick);
`default_nettype wire

/* File: dv/test_clk_cfg_block.sv */
/*
  self-checking bench for the clock configuration block.
  assumes the axi4-lite timing of the block and a 200 mhz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_clk_cfg_block;
  import clk_cfg_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, rst, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, pd, pll_output_enable_n, osc, tick;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  bresp, rresp;
  logic [5:0]  div;
  logic        ce;
  logic [3:0]  ws;
  int err_total, total_checks;
  clk_cfg_block dut_u (.i_core_clk(clk), .i_reset(rst), .i_clk_en(ce),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv),
    .i_s_axi_rready(rr), .o_pll_power_down(pd), .o_pll_output_enable_n(pll_output_enable_n),
    .o_sel_oscillator(osc), .o_eff_divisor(div), .o_sys_tick(tick));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1; aw = 1'b1; w = 1'b1;
    do begin
      @(posedge clk);
      if (aw && awr) begin awv <= 1'b0; aw = 1'b0; end
      if (w && wr_) begin wv <= 1'b0; w = 1'b0; end
    end while (aw || w);
    while (!bv) @(posedge clk);
    br <= 1'b0;
    chk({30'h0, bresp}, {30'h0, resp_okay});
    repeat (3) @(posedge clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge clk);
    rr <= 1'b0;
    chk(rd, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic period(input int exp);
    int n;
    repeat (2) begin
      do @(posedge clk); while (!tick);
    end
    n = 0;
    do begin @(posedge clk); n++; end while (!tick);
    chk(n, exp);
  endtask
  task automatic outs(input logic [8:0] exp);
    chk({23'h0, pd, pll_output_enable_n, osc, div}, {23'h0, exp});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    outs({3'b111, 6'h0f});
    rdc(run_cfg_offset, 32'h0780_3ac0, resp_okay);
    rdc(second_cfg_offset, 32'h0780_0000, resp_okay);
    period(1);
  endtask
  task automatic t_reserved;
    wr(run_cfg_offset, 32'hffff_ffff);
    rdc(run_cfg_offset, 32'h0fc0_3fff, resp_okay);
    outs({3'b111, 6'h0f});
    period(16);
    wr(run_cfg_offset, 32'h0000_0000);
    outs({3'b000, 6'h00});
  endtask
  task automatic t_divide;
    wr(run_cfg_offset, 32'h0180_0000);
    outs({3'b000, 6'h03});
    period(4);
    wr(run_cfg_offset, 32'h0140_0800);
    period(3);
    chk({31'h0, osc}, 32'h1);
  endtask
  task automatic t_override;
    wr(second_cfg_offset, 32'h8280_0000);
    rdc(status_offset, 32'h0000_0016, resp_okay);
    period(6);
    wr(second_cfg_offset, 32'h0280_0000);
    period(3);
    rdc(12'h004, 32'h0000_0000, resp_slverr);
  endtask
  task automatic t_stall;
    logic v;
    int n;
    ws <= 4'h2;
    wr(run_cfg_offset, 32'h0000_0000);
    ws <= 4'hf;
    rdc(run_cfg_offset, 32'h0140_0000, resp_okay);
    chk({31'h0, osc}, 32'h0);
    @(posedge clk);
    ara <= status_offset;
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    repeat (3) @(posedge clk);
    rr <= 1'b1;
    do @(posedge clk); while (!rv);
    rr <= 1'b0;
    chk(rd, 32'h0000_0008);
    chk({30'h0, rresp}, {30'h0, resp_okay});
    ce <= 1'b0;
    @(posedge clk);
    v = tick;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      if (tick !== v) n++;
    end
    ce <= 1'b1;
    chk(n, 0);
    period(3);
  endtask
  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
  initial begin
    err_total = 0; total_checks = 0; rst = 1'b1; awv = 1'b0; wv = 1'b0; br = 1'b0;
    arv = 1'b0; rr = 1'b0; awa = 12'h000; ara = 12'h000; wd = 32'h0;
    ce = 1'b1;
    ws = 4'hf;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_reserved();
    t_divide();
    t_override();
    t_stall();
    report_and_stop();
  end
endmodule // test_clk_cfg_block
`default_nettype wire

/* File: logic/clk_cfg_block.sv */
/*
  run-mode clock configuration: register file over axi4-lite, pll control
  outputs, system clock source select and divider.
  assumes a single clock; o_sys_tick is a clock enable for the system domain.
*/
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module clk_cfg_block
  import clk_cfg_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_clk_en,
  // axi4-lite write address
  input  wire logic [addr_width-1:0] i_s_axi_awaddr,
  input  wire logic                  i_s_axi_awvalid,
  output logic                       o_s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]           i_s_axi_wdata,
  input  wire logic [3:0]            i_s_axi_wstrb,
  input  wire logic                  i_s_axi_wvalid,
  output logic                       o_s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                 o_s_axi_bresp,
  output logic                       o_s_axi_bvalid,
  input  wire logic                  i_s_axi_bready,
  // axi4-lite read address
  input  wire logic [addr_width-1:0] i_s_axi_araddr,
  input  wire logic                  i_s_axi_arvalid,
  output logic                       o_s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                o_s_axi_rdata,
  output logic [1:0]                 o_s_axi_rresp,
  output logic                       o_s_axi_rvalid,
  input  wire logic                  i_s_axi_rready,
  // pll and clock tree
  output logic                       o_pll_power_down,
  output logic                       o_pll_output_enable_n,
  output logic                       o_sel_oscillator,
  output logic [5:0]                 o_eff_divisor,
  output logic                       o_sys_tick
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  aw_held;
    logic [addr_width-1:0] aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
    logic [31:0]           run_mode_clock_config;
    logic [31:0]           second_clock_config;
    logic                  pll_pd;
    logic                  pll_oen_n;
    logic                  sel_osc;
    logic [5:0]            eff_div;
    logic                  div_pass;
    logic                  aw_rdy;
    logic                  w_rdy;
    logic                  ar_rdy;
  } cfg_state_type;

  cfg_state_type state;
  cfg_state_type next_state;
  logic          tick;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  function automatic logic mapped(input logic [addr_width-1:0] a);
    return (a == run_cfg_offset) || (a == second_cfg_offset) || (a == status_offset);
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic        override;
    logic        bypass;
    logic [5:0]  div;
    next_state = state;
    override   = 1'b0;
    bypass     = 1'b0;
    div        = '0;
    // write channels, taken in either order
    if (!state.aw_held && i_s_axi_awvalid) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = i_s_axi_awaddr;
    end
    if (!state.w_held && i_s_axi_wvalid) begin
      next_state.w_held = 1'b1;
      next_state.w_data = i_s_axi_wdata;
      next_state.w_strb = i_s_axi_wstrb;
    end
    if (state.aw_held && state.w_held && !state.bvalid) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = mapped(state.aw_addr) ? resp_okay : resp_slverr;
      if (state.aw_addr == run_cfg_offset) begin
        next_state.run_mode_clock_config = merge(state.run_mode_clock_config,
          state.w_data, state.w_strb, run_cfg_wmask);
      end
      if (state.aw_addr == second_cfg_offset) begin
        next_state.second_clock_config = merge(state.second_clock_config,
          state.w_data, state.w_strb, second_cfg_wmask);
      end
    end
    if (state.bvalid && i_s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    // read channel
    if (!state.rvalid && i_s_axi_arvalid) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = mapped(i_s_axi_araddr) ? resp_okay : resp_slverr;
      case (i_s_axi_araddr)
        run_cfg_offset: begin
          next_state.rdata = state.run_mode_clock_config;
        end
        second_cfg_offset: begin
          next_state.rdata = state.second_clock_config;
        end
        status_offset: begin
          next_state.rdata = {24'h000000, state.eff_div, state.sel_osc, state.pll_pd};
        end
        default: begin
          next_state.rdata = 32'h0000_0000;
        end
      endcase
    end else if (state.rvalid && i_s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    // clock source and divisor selection
    override = state.second_clock_config[override_bit];
    bypass   = state.run_mode_clock_config[bypass_bit];
    if (override) begin
      div = state.second_clock_config[alt_div_msb:alt_div_lsb];
    end else begin
      div = {2'h0, state.run_mode_clock_config[div_msb:div_lsb]};
    end
    next_state.pll_pd    = state.run_mode_clock_config[pll_pd_bit];
    next_state.pll_oen_n = state.run_mode_clock_config[pll_oen_bit];
    next_state.sel_osc   = bypass;
    next_state.eff_div   = div;
    next_state.div_pass  = bypass && !state.run_mode_clock_config[div_apply];
    // ready flags registered so the bus outputs come straight from flops
    next_state.aw_rdy    = !next_state.aw_held;
    next_state.w_rdy     = !next_state.w_held;
    next_state.ar_rdy    = !next_state.rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state                       <= '0;
      state.run_mode_clock_config <= run_cfg_reset;
      state.second_clock_config   <= second_cfg_reset;
      state.pll_pd                <= run_cfg_reset[pll_pd_bit];
      state.pll_oen_n             <= run_cfg_reset[pll_oen_bit];
      state.sel_osc               <= run_cfg_reset[bypass_bit];
      state.eff_div               <= {2'h0, run_cfg_reset[div_msb:div_lsb]};
      state.div_pass              <= run_cfg_reset[bypass_bit] && !run_cfg_reset[div_apply];
      state.aw_rdy                <= 1'b1;
      state.w_rdy                 <= 1'b1;
      state.ar_rdy                <= 1'b1;
    end else if (i_clk_en) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // system clock divider
  // ----------------------------------------------------------------
  clk_divider #(
    .width (6)
  ) u_div (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_enable   (i_clk_en),
    .i_pass     (state.div_pass),
    .i_divisor  (state.eff_div),
    .o_tick     (tick)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_s_axi_awready       = state.aw_rdy;
  assign o_s_axi_wready        = state.w_rdy;
  assign o_s_axi_bresp         = state.bresp;
  assign o_s_axi_bvalid        = state.bvalid;
  assign o_s_axi_arready       = state.ar_rdy;
  assign o_s_axi_rdata         = state.rdata;
  assign o_s_axi_rresp         = state.rresp;
  assign o_s_axi_rvalid        = state.rvalid;
  assign o_pll_power_down      = state.pll_pd;
  assign o_pll_output_enable_n = state.pll_oen_n;
  assign o_sel_oscillator      = state.sel_osc;
  assign o_eff_divisor         = state.eff_div;
  assign o_sys_tick            = tick;
endmodule // clk_cfg_block
`default_nettype wire

/* File: logic/clk_cfg_pkg.sv */
/*
  constants for the run-mode clock configuration block: register offsets,
  field positions, reset values and bus responses.
  assumes an axi4-lite slave with 32-bit data and aligned word registers.
*/
package clk_cfg_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] run_cfg_offset    = 12'h060;
  localparam logic [11:0] second_cfg_offset = 12'h070;
  localparam logic [11:0] status_offset     = 12'h074;
  localparam int          addr_width        = 12;

  // ----------------------------------------------------------------
  // run-mode register fields
  // ----------------------------------------------------------------
  localparam int div_lsb      = 23;
  localparam int div_msb      = 26;
  localparam int div_apply    = 22;
  localparam int rsv_lsb      = 14;
  localparam int rsv_msb      = 21;
  localparam int pll_pd_bit   = 13;
  localparam int pll_oen_bit  = 12;
  localparam int bypass_bit   = 11;
  localparam logic [31:0] run_cfg_reset  = 32'h0780_3ac0;
  // writable bits: 27, 26:22, 13:0 ; 31:28 and 21:14 read zero
  localparam logic [31:0] run_cfg_wmask  = 32'h0fc0_3fff;

  // ----------------------------------------------------------------
  // second register fields
  // ----------------------------------------------------------------
  localparam int          override_bit    = 31;
  localparam int          alt_div_lsb     = 23;
  localparam int          alt_div_msb     = 28;
  localparam logic [31:0] second_cfg_reset = 32'h0780_0000;
  localparam logic [31:0] second_cfg_wmask = 32'h9f80_0000;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : clk_cfg_pkg

/* File: logic/clk_divider.sv */
/*
  programmable clock-enable divider: emits one pulse every (divisor+1) cycles,
  or every cycle when bypassed.
  assumes divisor changes take effect at once, as the count is compared with i_divisor every cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module clk_divider #(
  parameter int width = 6
) (
  // clock and control
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  input  wire logic             i_enable,
  // divider setup
  input  wire logic             i_pass,
  input  wire logic [width-1:0] i_divisor,
  // output
  output logic                  o_tick
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [width-1:0] count;
    logic             tick;
  } div_state_type;

  div_state_type state;
  div_state_type next_state;

  always_comb begin
    next_state = state;
    if (i_pass) begin
      next_state.count = '0;
      next_state.tick  = 1'b1;
    end else if (state.count >= i_divisor) begin
      next_state.count = '0;
      next_state.tick  = 1'b1;
    end else begin
      next_state.count = state.count + 1'b1;
      next_state.tick  = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state <= '0;
    end else if (i_enable) begin
      state <= next_state;
    end
  end

  assign o_tick = state.tick;
endmodule // clk_divider
`default_nettype wire
